/* verification/mbfrm_master_assertions.sv */
// port assertions of the master framer
`timescale 1ns/1ps
module mbfrm_master_assertions
  import mbfrm_pkg::*;
(
  input wire logic                    i_core_clk,     // clock
  input wire logic                    i_rst_n,        // reset
  input wire logic                    i_cmd_valid,    // command offered
  input wire mbfrm_pkg::mbfrm_cmd_t   i_cmd,          // command
  input wire logic                    o_cmd_ready,    // idle
  input wire logic                    i_cfg_wr,       // store settings
  input wire logic                    i_factory_req,  // arm restore
  input wire logic                    i_reboot,       // reboot
  input wire logic                    o_restore_pend, // restore armed
  input wire mbfrm_pkg::mbfrm_cfg_t   o_cfg,          // settings
  input wire logic                    o_tx_valid,     // query valid
  input wire logic [7:0]              o_tx_byte,      // query byte
  input wire logic                    i_tx_ready,     // line ready
  input wire mbfrm_pkg::mbfrm_img_wr_t o_img_wr,      // image write
  input wire logic                    o_done,         // finished
  input wire mbfrm_pkg::mbfrm_status_t o_status       // outcome
);
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_rst_n);
  mbfrm_cmd_t cmd_reg;
  logic [7:0] idx_reg;
  logic       wr_reg;
  mbfrm_img_t tgt;
  // read codes 01..04 map to image order minus one
  assign tgt = mbfrm_img_t'(cmd_reg.func[1:0] - 2'd1);
  always_ff @(posedge i_core_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      cmd_reg <= '0;
      idx_reg <= '0;
      wr_reg <= 1'b0;
    end
    else if (i_cmd_valid && o_cmd_ready)
    begin
      cmd_reg <= i_cmd;
      idx_reg <= '0;
      wr_reg <= 1'b0;
    end
    else
    begin
      if (o_tx_valid && i_tx_ready)
        idx_reg <= idx_reg + 8'h01;
      if (o_img_wr.valid)
        wr_reg <= 1'b1;
    end
  end
  sequence s_take;
    i_cmd_valid && o_cmd_ready;
  endsequence
  sequence s_go;
    s_take ##1 !o_done;
  endsequence
  AST_FIRST_SLAVE: assert property (s_go |=> o_tx_valid &&
    o_tx_byte == cmd_reg.slave) else $error("first byte not address");
  AST_ADDR_RANGE: assert property (o_tx_valid && idx_reg == 0 |->
    o_tx_byte inside {[8'h01:8'hF7]}) else $error("address out of range");
  AST_FUNC_CODE: assert property (o_tx_valid && idx_reg == 1 |->
    o_tx_byte == cmd_reg.func && o_tx_byte inside {[8'h01:8'h06],
    8'h0F, 8'h10}) else $error("bad function byte");
  AST_START_HI: assert property (o_tx_valid && idx_reg == 2 |->
    o_tx_byte == cmd_reg.start[15:8]) else $error("start high wrong");
  AST_COUNT_HI: assert property (o_tx_valid && idx_reg == 4 &&
    cmd_reg.func inside {[8'h01:8'h04]} |-> o_tx_byte == cmd_reg.count[15:8])
    else $error("count high wrong");
  AST_COIL_FORCE: assert property (o_tx_valid && cmd_reg.func == 8'h05 &&
    idx_reg inside {4, 5} |-> o_tx_byte == ((idx_reg == 4 && cmd_reg.coil_on)
    ? 8'hFF : 8'h00)) else $error("coil force data wrong");
  AST_IMG_TGT: assert property (o_img_wr.valid |->
    o_img_wr.tgt == tgt) else $error("wrong image written");
  AST_NO_WR_FAIL: assert property (o_done && o_status != MBFRM_OK |->
    !wr_reg && !o_img_wr.valid) else $error("image written on failure");
  AST_RESTORE: assert property (i_reboot && o_restore_pend &&
    !i_factory_req && !i_cfg_wr |=> o_cfg == '0 && !o_restore_pend)
    else $error("defaults not restored");
endmodule : mbfrm_master_assertions
bind mbfrm_master mbfrm_master_assertions u_chk (
  .i_core_clk(i_core_clk), .i_rst_n(i_rst_n), .i_cmd_valid(i_cmd_valid),
  .i_cmd(i_cmd), .o_cmd_ready(o_cmd_ready), .i_cfg_wr(i_cfg_wr),
  .i_factory_req(i_factory_req), .i_reboot(i_reboot),
  .o_restore_pend(o_restore_pend), .o_cfg(o_cfg), .o_tx_valid(o_tx_valid),
  .o_tx_byte(o_tx_byte), .i_tx_ready(i_tx_ready), .o_img_wr(o_img_wr),
  .o_done(o_done), .o_status(o_status));

/* verification/mbfrm_slave_model.sv */
// behavioural serial-line slave that takes queries and plays responses
`timescale 1ns/1ps
module mbfrm_slave_model (
  input  wire logic       i_clk,      // core clock
  input  wire logic       i_tx_valid, // query byte valid
  input  wire logic [7:0] i_tx_byte,  // query byte
  output logic            o_tx_ready, // takes query byte
  output logic            o_rx_valid, // response byte valid
  output logic [7:0]      o_rx_byte   // response byte
);
  logic [7:0] q[$];
  logic       slow;
  int         cyc;
  initial
  begin
    slow = 0;
    cyc = 0;
    o_tx_ready = 1;
    o_rx_valid = 0;
    o_rx_byte = 8'h00;
  end
  // a slow line refuses every other cycle so the query must hold
  always @(posedge i_clk)
  begin
    if (i_tx_valid && o_tx_ready)
      q.push_back(i_tx_byte);
    cyc++;
    #1;
    o_tx_ready = !slow || cyc[0];
  end
  function automatic logic [15:0] crc16(input logic [7:0] b[$]);
    logic [15:0] c;
    c = 16'hFFFF;
    foreach (b[i])
    begin
      c ^= {8'h00, b[i]};
      repeat (8) c = c[0] ? (c >> 1) ^ 16'hA001 : c >> 1;
    end
    return c;
  endfunction : crc16
  task automatic send(input logic [7:0] b[$], input logic bad);
    logic [15:0] c = crc16(b) ^ {15'h0, bad};
    b.push_back(c[7:0]);
    b.push_back(c[15:8]);
    foreach (b[i])
    begin
      @(posedge i_clk);
      #1;
      o_rx_valid = 1;
      o_rx_byte = b[i];
    end
    @(posedge i_clk);
    #1;
    o_rx_valid = 0;
    // a released line must not keep showing the last byte
    o_rx_byte = ~o_rx_byte;
  endtask : send
endmodule : mbfrm_slave_model

/* verification/tb_modbus_rtu_master_framer.sv */
// self-checking bench of the serial-line master framer
`timescale 1ns/1ps
module tb_modbus_rtu_master_framer;
  import mbfrm_pkg::*;
  logic          clk, rst_n, cmd_valid, ready, cfg_wr, fac, reboot, pend;
  logic          tx_valid, tx_ready, rx_valid, done;
  logic [7:0]    tx_byte, rx_byte, exc;
  logic [15:0]   rd_addr, rd_data;
  mbfrm_cmd_t    cmd;
  mbfrm_cfg_t    cfg, cfg_q;
  mbfrm_img_t    rd_tgt;
  mbfrm_img_wr_t img_wr;
  mbfrm_status_t status, st;
  mbfrm_img_wr_t wq[$];
  int            n_errors = 0, tests_run = 0, n_done = 0, cyc = 0;
  // image data made from address and target
  assign rd_data = {rd_addr[7:0] ^ 8'h5A, rd_addr[7:0] ^ {6'h00, rd_tgt}};
  mbfrm_master #(.TIMEOUT_CYCLES(50)) DUT (.i_core_clk(clk),
    .i_rst_n(rst_n), .i_cmd_valid(cmd_valid), .i_cmd(cmd),
    .o_cmd_ready(ready), .i_cfg_wr(cfg_wr), .i_cfg(cfg), .o_cfg(cfg_q),
    .i_factory_req(fac), .i_reboot(reboot), .o_restore_pend(pend),
    .o_tx_valid(tx_valid), .o_tx_byte(tx_byte), .i_tx_ready(tx_ready),
    .i_rx_valid(rx_valid), .i_rx_byte(rx_byte), .o_img_rd_tgt(rd_tgt),
    .o_img_rd_addr(rd_addr), .i_img_rd_data(rd_data), .o_img_wr(img_wr),
    .o_done(done), .o_status(status), .o_exc_code(exc));
  mbfrm_slave_model PM (.i_clk(clk), .i_tx_valid(tx_valid),
    .i_tx_byte(tx_byte), .o_tx_ready(tx_ready), .o_rx_valid(rx_valid),
    .o_rx_byte(rx_byte));
  initial
  begin
    clk = 0;
    forever #12.5 clk = ~clk;
  end
  always @(posedge clk)
  begin
    cyc++;
    if (done)
      n_done++;
    if (done)
      st = status;
    if (img_wr.valid)
      wq.push_back(img_wr);
    if (cyc == 20000)
    begin
      n_errors++;
      summarize();
    end
  end
  task automatic cmp(input logic [31:0] g, input logic [31:0] e);
    tests_run++;
    if (g !== e)
    begin
      n_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, g, e);
    end
  endtask : cmp
  task automatic tick();
    @(posedge clk);
    #1;
  endtask : tick
  task automatic chk_tx(input logic [7:0] b[$]);
    logic [15:0] c = PM.crc16(b);
    b.push_back(c[7:0]);
    b.push_back(c[15:8]);
    cmp(PM.q.size(), b.size());
    foreach (b[i])
      if (i < PM.q.size())
        cmp(PM.q[i], b[i]);
  endtask : chk_tx
  task automatic set_cfg(input logic r, input logic b);
    cfg = {r, b};
    cfg_wr = 1;
    tick();
    cfg_wr = 0;
    cmp(cfg_q, {r, b});
  endtask : set_cfg
  task automatic run(input mbfrm_cmd_t c, input logic [7:0] r[$],
                     input logic bad);
    int d0 = n_done;
    int t = 0;
    PM.q.delete();
    wq.delete();
    cmd = c;
    cmd_valid = 1;
    tick();
    cmd_valid = 0;
    while (n_done == d0 && (PM.q.size() == 0 || tx_valid) && t < 300)
    begin
      tick();
      t++;
    end
    if (n_done == d0 && r.size() > 0)
      PM.send(r, bad);
    while (n_done == d0 && t < 600)
    begin
      tick();
      t++;
    end
    cmp(n_done - d0, 1);
  endtask : run
  task automatic t_reads();
    mbfrm_cmd_t  c;
    logic [7:0]  r[$];
    logic [15:0] w, g;
    for (int s = 0; s < 2; s++)
      for (int f = 1; f < 5; f++)
      begin
        set_cfg(s[0], s[0]);
        PM.slow = s[0];
        c = '0;
        c.func = 8'(f);
        c.slave = s ? 8'hF7 : 8'h01;
        c.start = 16'h0013;
        c.count = f < 3 ? 16'd10 : 16'd2;
        c.img_addr = 16'h0100;
        r = {c.slave, c.func, 8'h02 << (f > 2)};
        for (int i = 0; i < r[2]; i++)
          r.push_back(8'hA0 + 8'(i));
        run(c, r, 0);
        chk_tx({c.slave, c.func, 8'h00, 8'h13, 8'h00, c.count[7:0]});
        cmp(st, MBFRM_OK);
        cmp(wq.size(), 2);
        for (int i = 0; i < 2 && i < wq.size(); i++)
        begin
          g = f < 3 ? {8'h00, wq[i].data[7:0]} : wq[i].data;
          w = f < 3 ? {8'h00, r[3 + (i ^ s)]} : s ? {r[4 + 2*i], r[3 + 2*i]}
            : {r[3 + 2*i], r[4 + 2*i]};
          cmp(wq[i].tgt, f - 1);
          cmp(wq[i].addr, 16'h0100 + i);
          cmp(g, w);
        end
      end
    PM.slow = 0;
  endtask : t_reads
  task automatic t_writes();
    mbfrm_cmd_t c;
    logic [7:0] b[$];
    logic [7:0] fn[5] = '{8'h05, 8'h05, 8'h06, 8'h0F, 8'h10};
    set_cfg(0, 0);
    for (int k = 0; k < 5; k++)
    begin
      c = '0;
      c.func = fn[k];
      c.slave = 8'h11;
      c.start = 16'h0102;
      c.img_addr = 16'h0040;
      c.wr_value = 16'hBEEF;
      c.coil_on = k == 0;
      c.count = k == 3 ? 16'd8 : 16'd1;
      b = {c.slave, c.func, 8'h01, 8'h02};
      case (k)
        0: b = {b, 8'hFF, 8'h00};
        1: b = {b, 8'h00, 8'h00};
        2: b = {b, 8'hBE, 8'hEF};
        3: b = {b, 8'h00, 8'h08, 8'h01, 8'h40};
        default: b = {b, 8'h00, 8'h01, 8'h02, 8'h1A, 8'h42};
      endcase
      run(c, b[0:5], 0);
      chk_tx(b);
      cmp(st, MBFRM_OK);
    end
  endtask : t_writes
  task automatic t_errors();
    mbfrm_cmd_t    c;
    logic [7:0]    r[$];
    for (int k = 0; k < 8; k++)
    begin
      c = '0;
      c.func = k == 0 ? 8'h07 : 8'h03;
      c.slave = k == 1 ? 8'h00 : k == 2 ? 8'hF8 : 8'h09;
      c.count = k == 3 ? 16'd0 : 16'd1;
      r = {8'h09, 8'h03, 8'h02, 8'h12, 8'h34};
      if (k == 5)
        r[0] = 8'h0A;
      if (k == 6)
        r = {8'h09, 8'h83, 8'h02};
      if (k < 4 || k == 7)
        r = {};
      run(c, r, k == 4);
      cmp(st, k < 4 ? MBFRM_REJECTED : k - 2);
      cmp(wq.size(), 0);
      if (k < 4)
        cmp(PM.q.size(), 0);
      if (k == 6)
        cmp(exc, 8'h02);
    end
  endtask : t_errors
  task automatic t_restore();
    set_cfg(1, 1);
    fac = 1;
    tick();
    fac = 0;
    cmp(pend, 1);
    reboot = 1;
    tick();
    reboot = 0;
    tick();
    cmp(cfg_q, 2'b00);
    cmp(pend, 0);
  endtask : t_restore
  task automatic summarize();
    $display("comparisons %0d errors %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : summarize
  initial
  begin
    {rst_n, cmd_valid, cfg_wr, fac, reboot} = '0;
    cmd = '0;
    cfg = '0;
    repeat (10) @(posedge clk);
    #1;
    rst_n = 1;
    repeat (3) @(posedge clk);
    #1;
    t_reads();
    t_writes();
    t_errors();
    t_restore();
    summarize();
  end
endmodule : tb_modbus_rtu_master_framer

/* verilog/mbfrm_crc_step.sv */
// one byte step of the reflected 16-bit frame check
`timescale 1ns/1ps
module mbfrm_crc_step
  import mbfrm_pkg::*;
(
  input  wire logic [15:0] i_crc,  // running value
  input  wire logic [7:0]  i_byte, // byte to fold in
  output logic      [15:0] o_crc   // value after the byte
);
  always_comb
  begin
    logic [15:0] c;
    c = i_crc ^ {8'h00, i_byte};
    for (int b = 0; b < 8; b++)
    begin
      if (c[0])
        c = (c >> 1) ^ `MBFRM_CRC_POLY;
      else
        c = c >> 1;
    end
    o_crc = c;
  end
endmodule : mbfrm_crc_step

/* verilog/mbfrm_master.sv */
// query builder and response parser of the serial-line master
`timescale 1ns/1ps
module mbfrm_master
  import mbfrm_pkg::*;
#(
  parameter int TIMEOUT_CYCLES = `MBFRM_TIMEOUT_CYC
)
(
  input  wire logic                    i_core_clk,    // 40 MHz clock
  input  wire logic                    i_rst_n,       // async reset
  input  wire logic                    i_cmd_valid,   // command offered
  input  wire mbfrm_pkg::mbfrm_cmd_t   i_cmd,         // command fields
  output logic                         o_cmd_ready,   // idle, takes cmd
  input  wire logic                    i_cfg_wr,      // store settings
  input  wire mbfrm_pkg::mbfrm_cfg_t   i_cfg,         // swap settings
  output mbfrm_pkg::mbfrm_cfg_t        o_cfg,         // stored settings
  input  wire logic                    i_factory_req, // arm restore
  input  wire logic                    i_reboot,      // soft reboot
  output logic                         o_restore_pend,// restore armed
  output logic                         o_tx_valid,    // query byte valid
  output logic [7:0]                   o_tx_byte,     // query byte
  input  wire logic                    i_tx_ready,    // line takes byte
  input  wire logic                    i_rx_valid,    // response byte
  input  wire logic [7:0]              i_rx_byte,     // response data
  output mbfrm_pkg::mbfrm_img_t        o_img_rd_tgt,  // image to read
  output logic [15:0]                  o_img_rd_addr, // read address
  input  wire logic [15:0]             i_img_rd_data, // read data
  output mbfrm_pkg::mbfrm_img_wr_t     o_img_wr,      // image write
  output logic                         o_done,        // command finished
  output mbfrm_pkg::mbfrm_status_t     o_status,      // outcome
  output logic [7:0]                   o_exc_code     // exception code
);
  import mbfrm_pkg::*;

  localparam int BUF_N = `MBFRM_BUF_BYTES;

  typedef struct packed {
    mbfrm_fsm_t            fsm;
    mbfrm_cmd_t            cmd;
    mbfrm_cfg_t            cfg;
    logic                  restore_pend;
    logic [7:0]            idx;
    logic [7:0]            body;
    logic [15:0]           crc;
    logic                  bad_hdr;
    logic                  bad_crc;
    logic                  exc;
    logic [31:0]           timer;
    logic                  tx_valid;
    logic [7:0]            tx_byte;
    logic [BUF_N-1:0][7:0] buf_q;
    mbfrm_img_wr_t         img_wr;
    logic                  done;
    mbfrm_status_t         status;
    logic [7:0]            exc_code;
  } mbfrm_state_t;

  mbfrm_state_t st_reg;
  mbfrm_state_t st_next;
  logic [1:0]   rst_sync_reg;
  logic         rst_n;
  logic [15:0]  crc_tx;
  logic [15:0]  crc_rx;
  logic [7:0]   tx_nb;

  function automatic logic f_is_bit_rd(input logic [7:0] fn);
    return fn == `MBFRM_FN_RD_COIL || fn == `MBFRM_FN_RD_DIN;
  endfunction : f_is_bit_rd

  function automatic logic f_is_read(input logic [7:0] fn);
    return f_is_bit_rd(fn) || fn == `MBFRM_FN_RD_HREG ||
           fn == `MBFRM_FN_RD_IREG;
  endfunction : f_is_read

  function automatic logic f_is_multi(input logic [7:0] fn);
    return fn == `MBFRM_FN_WR_COILS || fn == `MBFRM_FN_WR_REGS;
  endfunction : f_is_multi

  // bytes carried by a data field of this command
  function automatic logic [7:0] f_data_bytes(input mbfrm_cmd_t c);
    logic [15:0] n;
    if (f_is_bit_rd(c.func) || c.func == `MBFRM_FN_WR_COILS)
      n = (c.count + 16'h0007) >> 3;
    else
      n = c.count << 1;
    return n[7:0];
  endfunction : f_data_bytes

  function automatic logic f_cmd_ok(input mbfrm_cmd_t c);
    logic fn_ok;
    logic ad_ok;
    logic multi;
    logic [16:0] n;
    fn_ok = f_is_read(c.func) || c.func == `MBFRM_FN_WR_COIL ||
            c.func == `MBFRM_FN_WR_REG || f_is_multi(c.func);
    ad_ok = c.slave >= `MBFRM_ADDR_MIN &&
            c.slave <= `MBFRM_ADDR_MAX;
    multi = f_is_read(c.func) || f_is_multi(c.func);
    // the response buffer bounds how many items one query may move
    if (f_is_bit_rd(c.func) || c.func == `MBFRM_FN_WR_COILS)
      n = ({1'b0, c.count} + 17'h00007) >> 3;
    else
      n = {c.count, 1'b0};
    return fn_ok && ad_ok &&
           (!multi || (c.count != 16'h0000 &&
                       n <= 17'(BUF_N)));
  endfunction : f_cmd_ok

  function automatic mbfrm_img_t f_tgt(input logic [7:0] fn);
    case (fn)
      `MBFRM_FN_RD_COIL, `MBFRM_FN_WR_COILS: return MBFRM_IMG_COIL;
      `MBFRM_FN_RD_DIN:  return MBFRM_IMG_DIN;
      `MBFRM_FN_RD_IREG: return MBFRM_IMG_IREG;
      default:           return MBFRM_IMG_HREG;
    endcase
  endfunction : f_tgt

  // pair swap of bit bytes; an odd last byte stays in place
  function automatic logic [7:0] f_bit_idx(input logic [7:0] k,
                                           input logic [7:0] n,
                                           input logic       sw);
    logic [7:0] p;
    p = {k[7:1], ~k[0]};
    return (sw && p < n) ? p : k;
  endfunction : f_bit_idx

  always_ff @(posedge i_core_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      rst_sync_reg <= 2'b00;
    else
      rst_sync_reg <= {rst_sync_reg[0], 1'b1};
  end
  assign rst_n = rst_sync_reg[1];

  mbfrm_crc_step u_crc_tx (
    .i_crc  (st_reg.crc),
    .i_byte (tx_nb),
    .o_crc  (crc_tx)
  );

  mbfrm_crc_step u_crc_rx (
    .i_crc  (st_reg.crc),
    .i_byte (i_rx_byte),
    .o_crc  (crc_rx)
  );

  // next query byte at index idx, with the image read it needs
  always_comb
  begin
    logic [7:0] k;
    logic       multi;
    logic [7:0] hdr;
    logic [7:0] nd;
    logic [7:0] src;
    k     = st_reg.idx - `MBFRM_HDR_LEN_MULT;
    multi = f_is_multi(st_reg.cmd.func);
    hdr   = multi ? `MBFRM_HDR_LEN_MULT : `MBFRM_HDR_LEN;
    nd    = multi ? f_data_bytes(st_reg.cmd) : 8'h00;
    src   = f_bit_idx(k, nd, st_reg.cfg.swap_bit);
    o_img_rd_tgt  = f_tgt(st_reg.cmd.func);
    if (st_reg.cmd.func == `MBFRM_FN_WR_COILS)
      o_img_rd_addr = st_reg.cmd.img_addr + {8'h00, src};
    else
      o_img_rd_addr = st_reg.cmd.img_addr + {9'h000, k[7:1]};
    case (st_reg.idx)
      8'h00: tx_nb = st_reg.cmd.slave;
      8'h01: tx_nb = st_reg.cmd.func;
      8'h02: tx_nb = st_reg.cmd.start[15:8];
      8'h03: tx_nb = st_reg.cmd.start[7:0];
      8'h04:
      begin
        if (st_reg.cmd.func == `MBFRM_FN_WR_COIL)
          tx_nb = st_reg.cmd.coil_on ? `MBFRM_COIL_ON
                                     : `MBFRM_COIL_OFF;
        else if (st_reg.cmd.func == `MBFRM_FN_WR_REG)
          tx_nb = st_reg.cmd.wr_value[15:8];
        else
          tx_nb = st_reg.cmd.count[15:8];
      end
      8'h05:
      begin
        if (st_reg.cmd.func == `MBFRM_FN_WR_COIL)
          tx_nb = `MBFRM_COIL_OFF;
        else if (st_reg.cmd.func == `MBFRM_FN_WR_REG)
          tx_nb = st_reg.cmd.wr_value[7:0];
        else
          tx_nb = st_reg.cmd.count[7:0];
      end
      default:
      begin
        if (st_reg.idx == hdr + nd)
          tx_nb = st_reg.crc[7:0];
        else if (st_reg.idx == hdr + nd + 8'h01)
          tx_nb = st_reg.crc[15:8];
        else if (st_reg.idx == 8'h06)
          tx_nb = nd;
        else if (st_reg.cmd.func == `MBFRM_FN_WR_COILS)
          tx_nb = i_img_rd_data[7:0];
        else if (k[0] ^ st_reg.cfg.swap_reg)
          tx_nb = i_img_rd_data[7:0];
        else
          tx_nb = i_img_rd_data[15:8];
      end
    endcase
  end

  always_comb
  begin
    logic [7:0] body_tx;
    logic [7:0] nd;
    logic [7:0] src;
    logic [7:0] lo;
    logic [7:0] hi;
    st_next = st_reg;
    st_next.done = 1'b0;
    st_next.img_wr.valid = 1'b0;
    nd      = f_data_bytes(st_reg.cmd);
    body_tx = f_is_multi(st_reg.cmd.func) ? `MBFRM_HDR_LEN_MULT + nd
                                          : `MBFRM_HDR_LEN;
    src     = f_bit_idx(st_reg.idx, nd, st_reg.cfg.swap_bit);
    lo      = st_reg.buf_q[st_reg.idx[`MBFRM_BUF_IDX_W-1:0]];
    hi      = st_reg.buf_q[src[`MBFRM_BUF_IDX_W-1:0]];

    if (i_cfg_wr && st_reg.fsm == MBFRM_ST_IDLE)
      st_next.cfg = i_cfg;
    if (i_factory_req)
      st_next.restore_pend = 1'b1;
    if (i_reboot && st_reg.restore_pend)
    begin
      // restore only lands on the reboot after the request
      st_next.cfg.swap_reg = `MBFRM_SWAP_REG_RST;
      st_next.cfg.swap_bit = `MBFRM_SWAP_BIT_RST;
      st_next.restore_pend = i_factory_req;
    end

    case (st_reg.fsm)
      MBFRM_ST_IDLE:
      begin
        if (i_cmd_valid)
        begin
          st_next.cmd = i_cmd;
          st_next.idx = 8'h00;
          st_next.crc = `MBFRM_CRC_PRESET;
          if (f_cmd_ok(i_cmd))
            st_next.fsm = MBFRM_ST_TX;
          else
          begin
            st_next.done   = 1'b1;
            st_next.status = MBFRM_REJECTED;
          end
        end
      end
      MBFRM_ST_TX:
      begin
        if (!st_reg.tx_valid || i_tx_ready)
        begin
          if (st_reg.idx < body_tx + 8'h02)
          begin
            st_next.tx_valid = 1'b1;
            st_next.tx_byte  = tx_nb;
            st_next.idx      = st_reg.idx + 8'h01;
            if (st_reg.idx < body_tx)
              st_next.crc = crc_tx;
          end
          else
          begin
            st_next.tx_valid = 1'b0;
            st_next.fsm      = MBFRM_ST_RX;
            st_next.idx      = 8'h00;
            st_next.body     = `MBFRM_BODY_UNKNOWN;
            st_next.crc      = `MBFRM_CRC_PRESET;
            st_next.bad_hdr  = 1'b0;
            st_next.bad_crc  = 1'b0;
            st_next.exc      = 1'b0;
            st_next.timer    = 32'h00000000;
          end
        end
      end
      MBFRM_ST_RX:
      begin
        st_next.timer = st_reg.timer + 32'h00000001;
        if (i_rx_valid)
        begin
          st_next.timer = 32'h00000000;
          st_next.idx   = st_reg.idx + 8'h01;
          if (st_reg.idx < st_reg.body)
            st_next.crc = crc_rx;
          if (st_reg.idx == 8'h00)
          begin
            if (i_rx_byte != st_reg.cmd.slave)
              st_next.bad_hdr = 1'b1;
          end
          else if (st_reg.idx == 8'h01)
          begin
            if (i_rx_byte == st_reg.cmd.func)
            begin
              if (!f_is_read(st_reg.cmd.func))
                st_next.body = `MBFRM_RSP_WR_LEN;
            end
            else if (i_rx_byte ==
                     (st_reg.cmd.func | `MBFRM_EXC_FLAG))
            begin
              st_next.exc  = 1'b1;
              st_next.body = `MBFRM_RSP_HDR_LEN;
            end
            else
            begin
              st_next.fsm    = MBFRM_ST_IDLE;
              st_next.done   = 1'b1;
              st_next.status = MBFRM_MISMATCH;
            end
          end
          else if (st_reg.idx == 8'h02 && st_reg.exc)
            st_next.exc_code = i_rx_byte;
          else if (st_reg.idx == 8'h02 &&
                   f_is_read(st_reg.cmd.func))
          begin
            if (i_rx_byte == nd)
              st_next.body = `MBFRM_RSP_HDR_LEN + i_rx_byte;
            else
            begin
              st_next.fsm    = MBFRM_ST_IDLE;
              st_next.done   = 1'b1;
              st_next.status = MBFRM_MISMATCH;
            end
          end
          else if (st_reg.idx < st_reg.body)
          begin
            if (f_is_read(st_reg.cmd.func) && !st_reg.exc)
              st_next.buf_q[6'(st_reg.idx - 8'h03)] = i_rx_byte;
          end
          else if (st_reg.idx == st_reg.body)
          begin
            if (i_rx_byte != st_reg.crc[7:0])
              st_next.bad_crc = 1'b1;
          end
          else
          begin
            st_next.done = 1'b1;
            st_next.idx  = 8'h00;
            st_next.fsm  = MBFRM_ST_IDLE;
            if (st_reg.bad_crc || i_rx_byte != st_reg.crc[15:8])
              st_next.status = MBFRM_CRC_BAD;
            else if (st_reg.bad_hdr)
              st_next.status = MBFRM_MISMATCH;
            else if (st_reg.exc)
              st_next.status = MBFRM_EXCEPT;
            else if (f_is_read(st_reg.cmd.func))
            begin
              st_next.done = 1'b0;
              st_next.fsm  = MBFRM_ST_COMMIT;
            end
            else
              st_next.status = MBFRM_OK;
          end
        end
        else if (st_reg.timer >= 32'(TIMEOUT_CYCLES - 1))
        begin
          st_next.fsm    = MBFRM_ST_IDLE;
          st_next.done   = 1'b1;
          st_next.status = MBFRM_TIMEOUT;
        end
      end
      MBFRM_ST_COMMIT:
      begin
        // image is written only after the whole frame checked out
        st_next.img_wr.valid = 1'b1;
        st_next.img_wr.tgt   = f_tgt(st_reg.cmd.func);
        st_next.img_wr.addr  = st_reg.cmd.img_addr +
                               {8'h00, st_reg.idx};
        st_next.idx = st_reg.idx + 8'h01;
        if (f_is_bit_rd(st_reg.cmd.func))
          st_next.img_wr.data = {8'h00, hi};
        else
        begin
          hi = st_reg.buf_q[6'({st_reg.idx[6:0], 1'b0})];
          lo = st_reg.buf_q[6'({st_reg.idx[6:0], 1'b1})];
          st_next.img_wr.data = st_reg.cfg.swap_reg ? {lo, hi}
                                                    : {hi, lo};
        end
        if (f_is_bit_rd(st_reg.cmd.func) ? st_reg.idx + 8'h01 >= nd
            : {st_reg.idx + 8'h01, 1'b0} >= {1'b0, nd})
        begin
          st_next.fsm    = MBFRM_ST_IDLE;
          st_next.done   = 1'b1;
          st_next.status = MBFRM_OK;
        end
      end
      default:
        st_next.fsm = MBFRM_ST_IDLE;
    endcase
  end

  always_ff @(posedge i_core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st_reg              <= '0;
      st_reg.fsm          <= MBFRM_ST_IDLE;
      st_reg.cfg.swap_reg <= `MBFRM_SWAP_REG_RST;
      st_reg.cfg.swap_bit <= `MBFRM_SWAP_BIT_RST;
      st_reg.crc          <= `MBFRM_CRC_PRESET;
      st_reg.status       <= MBFRM_OK;
      st_reg.img_wr.tgt   <= MBFRM_IMG_COIL;
    end
    else
      st_reg <= st_next;
  end

  assign o_cmd_ready    = st_reg.fsm == MBFRM_ST_IDLE;
  assign o_cfg          = st_reg.cfg;
  assign o_restore_pend = st_reg.restore_pend;
  assign o_tx_valid     = st_reg.tx_valid;
  assign o_tx_byte      = st_reg.tx_byte;
  assign o_img_wr       = st_reg.img_wr;
  assign o_done         = st_reg.done;
  assign o_status       = st_reg.status;
  assign o_exc_code     = st_reg.exc_code;
endmodule : mbfrm_master

/* verilog/mbfrm_pkg.sv */
// types shared by the master framer files
package mbfrm_pkg;
  `include "mbfrm_regs.svh"

  typedef enum logic [3:0] {
    MBFRM_ST_IDLE   = 4'b0001,
    MBFRM_ST_TX     = 4'b0010,
    MBFRM_ST_RX     = 4'b0100,
    MBFRM_ST_COMMIT = 4'b1000
  } mbfrm_fsm_t;

  typedef enum logic [2:0] {
    MBFRM_OK       = 3'h0,
    MBFRM_REJECTED = 3'h1,
    MBFRM_CRC_BAD  = 3'h2,
    MBFRM_MISMATCH = 3'h3,
    MBFRM_EXCEPT   = 3'h4,
    MBFRM_TIMEOUT  = 3'h5
  } mbfrm_status_t;

  typedef enum logic [1:0] {
    MBFRM_IMG_COIL = 2'h0,
    MBFRM_IMG_DIN  = 2'h1,
    MBFRM_IMG_HREG = 2'h2,
    MBFRM_IMG_IREG = 2'h3
  } mbfrm_img_t;

  typedef struct packed {
    logic [7:0]  func;
    logic [7:0]  slave;
    logic [15:0] start;
    logic [15:0] count;
    logic        coil_on;
    logic [15:0] wr_value;
    logic [15:0] img_addr;
  } mbfrm_cmd_t;

  typedef struct packed {
    logic swap_reg;
    logic swap_bit;
  } mbfrm_cfg_t;

  typedef struct packed {
    logic        valid;
    mbfrm_img_t  tgt;
    logic [15:0] addr;
    logic [15:0] data;
  } mbfrm_img_wr_t;
endpackage : mbfrm_pkg

/* verilog/mbfrm_regs.svh */
// constants of the serial-line master framer
`ifndef MBFRM_REGS_SVH
`define MBFRM_REGS_SVH
`define MBFRM_FN_RD_COIL   8'h01
`define MBFRM_FN_RD_DIN    8'h02
`define MBFRM_FN_RD_HREG   8'h03
`define MBFRM_FN_RD_IREG   8'h04
`define MBFRM_FN_WR_COIL   8'h05
`define MBFRM_FN_WR_REG    8'h06
`define MBFRM_FN_WR_COILS  8'h0F
`define MBFRM_FN_WR_REGS   8'h10
`define MBFRM_EXC_FLAG     8'h80
`define MBFRM_COIL_ON      8'hFF
`define MBFRM_COIL_OFF     8'h00
`define MBFRM_ADDR_MIN     8'h01
`define MBFRM_ADDR_MAX     8'hF7
`define MBFRM_CRC_PRESET   16'hFFFF
`define MBFRM_CRC_POLY     16'hA001
`define MBFRM_BUF_BYTES    64
`define MBFRM_BUF_IDX_W    6
`define MBFRM_HDR_LEN      8'h06
`define MBFRM_HDR_LEN_MULT 8'h07
`define MBFRM_RSP_HDR_LEN  8'h03
`define MBFRM_RSP_WR_LEN   8'h06
`define MBFRM_BODY_UNKNOWN 8'hFF
`define MBFRM_SWAP_REG_RST 1'b0
`define MBFRM_SWAP_BIT_RST 1'b0
`define MBFRM_TIMEOUT_CYC  4000000
`endif
